// file: bench/rsw_host_mem.sv
// Host memory model: hands out buffer sizes, keeps written-back status words
`timescale 1ns/10ps
module rsw_host_mem (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Write-back from the device
  input  wire logic        desc_wr,
  input  wire logic [31:0] rx_status_word,
  // Sizes of the descriptor in use
  output logic [10:0]      desc_buf1_size,
  output logic [10:0]      desc_buf2_size
);
  logic [10:0] size1 [0:7];
  logic [10:0] size2 [0:7];
  logic [31:0] word  [0:7];
  int          n_words;

  // Ring of eight descriptors; sizes of the next one show right after a write-back
  assign desc_buf1_size = size1[n_words[2:0]];
  assign desc_buf2_size = size2[n_words[2:0]];

  initial begin
    for (int k = 0; k < 8; k++) begin
      size1[k] = 11'h7fc;
      size2[k] = 11'h7fc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_words <= 0;
    end else if (desc_wr) begin
      word[n_words[2:0]] <= rx_status_word;
      n_words <= n_words + 1;
    end
  end
endmodule // rsw_host_mem

// file: bench/tb_rsw_status.sv
// Self-checking testbench for the receive status word builder
`timescale 1ns/10ps
module tb_rsw_status;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr, rx_byte;
  logic [31:0] pwdata, prdata, rx_status_word, rd;
  logic        rx_sof, rx_byte_valid, rx_eof, rx_collision, rx_fifo_overflow, desc_wr;
  logic [2:0]  rx_extra_bits;
  logic [10:0] desc_buf1_size, desc_buf2_size;
  int          n_fail, tests_run;
  // The length field is outside this block, so only defined bits are compared
  localparam logic [31:0] CMP = 32'h8000_83f7;

  rsw_status i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_sof(rx_sof), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_eof(rx_eof),
    .rx_extra_bits(rx_extra_bits), .rx_collision(rx_collision),
    .rx_fifo_overflow(rx_fifo_overflow), .desc_buf1_size(desc_buf1_size),
    .desc_buf2_size(desc_buf2_size), .desc_wr(desc_wr), .rx_status_word(rx_status_word),
    .irq(irq));
  rsw_host_mem i_host (.pclk(pclk), .presetn(presetn), .desc_wr(desc_wr),
    .rx_status_word(rx_status_word), .desc_buf1_size(desc_buf1_size),
    .desc_buf2_size(desc_buf2_size));

  always #4 pclk = ~pclk;

  task automatic fail(input string msg);
    n_fail++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    tests_run++;
    if ((got & m) !== exp) fail($sformatf("word %h, expected %h", got & m, exp));
  endtask
  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask
  task automatic end_sim;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data and error are taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fail("bus timeout");
      end_sim();
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge pclk);
    #1 chk_b(irq, v);
  endtask

  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int j = 0; j < 8; j++) r = r[0] ? (r >> 1) ^ rsw_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction

  // Sends n bytes, the last four being the check sequence; bad spoils its last byte
  task automatic frame(input int n, input logic [15:0] lt, input bit bad,
                       input logic [2:0] xb, input int co, input int ov);
    logic [31:0] c;
    logic [7:0]  b;
    c = rsw_pkg::CRC_INIT;
    @(posedge pclk);
    rx_sof <= 1'b1;
    for (int i = 0; i < n; i++) begin
      if (i < n - 4) begin
        b = (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : i[7:0];
        c = crc8(c, b);
      end else begin
        b = ~c[8*(i-n+4) +: 8];
        if (bad && i == n - 1) b = ~b;
      end
      @(posedge pclk);
      rx_sof <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      rx_collision <= (i == co);
      rx_fifo_overflow <= (i == ov);
    end
    @(posedge pclk);
    {rx_byte_valid, rx_collision, rx_fifo_overflow} <= 3'h0;
    rx_eof <= 1'b1;
    rx_extra_bits <= xb;
    @(posedge pclk);
    rx_eof <= 1'b0;
    rx_extra_bits <= 3'h0;
  endtask
  task automatic wait_n(input int t);
    int k;
    for (k = 0; k < 64 && i_host.n_words < t; k++) @(posedge pclk);
    if (k == 64) begin
      fail("no write-back");
      end_sim();
    end
  endtask
  // One frame, one word back, and no stray second word
  task automatic run(input int n, input logic [15:0] lt, input bit bad, input logic [2:0] xb,
                     input int co, input int ov, input logic [31:0] exp);
    int b;
    b = i_host.n_words;
    frame(n, lt, bad, xb, co, ov);
    wait_n(b + 1);
    chk_w(i_host.word[b[2:0]], exp, CMP);
    repeat (3) @(posedge pclk);
    chk_b(i_host.n_words == b + 1, 1'b1);
  endtask

  task automatic t_regs;
    apb(0, rsw_pkg::OFF_CTRL, 0);
    chk_w(rd, rsw_pkg::CTRL_RESET, '1);
    apb(0, rsw_pkg::OFF_MASK, 0);
    chk_w(rd, rsw_pkg::MASK_RESET, '1);
    apb(1, 8'h20, 32'hffff_ffff);
    chk_b(err, 1'b1);
    apb(0, 8'h20, 0);
    chk_b(err, 1'b1);
    chk_w(rd, 32'h0, '1);
    $display("test registers done");
  endtask
  task automatic t_flags;
    run(64, 16'h0800, 0, 3'd0, -1, -1, 32'h320);
    run(64, 16'h05dc, 0, 3'd0, -1, -1, 32'h300);
    run(64, 16'h05dd, 0, 3'd0, -1, -1, 32'h320);
    run(64, 16'h002e, 0, 3'd3, -1, -1, 32'h304);
    run(64, 16'h002e, 0, 3'd2, -1, -1, 32'h300);
    run(64, 16'h002e, 1, 3'd6, -1, -1, 32'h8306);
    run(64, 16'h002e, 1, 3'd0, -1, -1, 32'h8302);
    run(64, 16'h002e, 0, 3'd0, -1, 30, 32'h8301);
    run(20, 16'h0800, 0, 3'd3, -1, -1, 32'h8320);
    run(13, 16'h0800, 0, 3'd0, -1, -1, 32'h8300);
    run(100, 16'h002e, 0, 3'd3, 70, -1, 32'h8340);
    run(100, 16'h002e, 0, 3'd3, 20, -1, 32'h304);
    run(1518, 16'h002e, 0, 3'd0, -1, -1, 32'h300);
    run(1519, 16'h002e, 0, 3'd0, -1, -1, 32'h8380);
    $display("test status flags done");
  endtask
  // Empty descriptor, frame starting in buffer two, then a middle one
  task automatic t_multi;
    int b;
    b = i_host.n_words;
    i_host.size1[b % 8] = 11'h0;
    i_host.size2[b % 8] = 11'h0;
    i_host.size1[(b + 1) % 8] = 11'h0;
    i_host.size2[(b + 1) % 8] = 11'h10;
    i_host.size1[(b + 2) % 8] = 11'h10;
    i_host.size2[(b + 2) % 8] = 11'h10;
    frame(80, 16'h002e, 0, 3'd0, -1, -1);
    wait_n(b + 4);
    chk_w(i_host.word[b % 8], 32'h0, CMP);
    chk_w(i_host.word[(b + 1) % 8], 32'h200, CMP);
    chk_w(i_host.word[(b + 2) % 8], 32'h0, CMP);
    chk_w(i_host.word[(b + 3) % 8], 32'h100, CMP);
    for (int k = 0; k < 8; k++) begin
      i_host.size1[k] = 11'h7fc;
      i_host.size2[k] = 11'h7fc;
    end
    $display("test descriptor chain done");
  endtask
  task automatic t_wdog;
    int b;
    apb(0, rsw_pkg::OFF_GSTAT, 0);
    apb(1, rsw_pkg::OFF_MASK, 32'h200);
    run(2047, 16'h002e, 0, 3'd0, -1, -1, 32'h8380);
    irq_is(1'b0);
    run(2048, 16'h002e, 0, 3'd0, -1, -1, 32'h8390);
    irq_is(1'b1);
    apb(1, rsw_pkg::OFF_MASK, 0);
    irq_is(1'b0);
    apb(1, rsw_pkg::OFF_MASK, 32'h200);
    irq_is(1'b1);
    apb(0, rsw_pkg::OFF_GSTAT, 0);
    chk_w(rd, 32'h203, 32'h203);
    irq_is(1'b0);
    apb(0, rsw_pkg::OFF_LASTWORD, 0);
    chk_w(rd, 32'h8390, CMP);
    chk_b(pready, 1'b1);
    // Disabled: a whole frame must be ignored
    apb(1, rsw_pkg::OFF_CTRL, 0);
    b = i_host.n_words;
    frame(64, 16'h002e, 0, 3'd0, -1, -1);
    repeat (4) @(posedge pclk);
    chk_b(i_host.n_words == b, 1'b1);
    apb(1, rsw_pkg::OFF_CTRL, 1);
    apb(0, rsw_pkg::OFF_FRAMES, 0);
    chk_w(rd, 32'h0000_0011, '1);
    $display("test watchdog and interrupt done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, rx_sof, rx_byte_valid, rx_eof, rx_collision} = '0;
    rx_fifo_overflow = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    rx_byte = 8'h0;
    rx_extra_bits = 3'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_flags();
    t_multi();
    t_wdog();
    end_sim();
  end
endmodule // tb_rsw_status

// file: src/rsw_pkg.sv
// Package of constants and types for the receive status word builder
package rsw_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_GSTAT     = 8'h04;
  localparam logic [7:0] OFF_MASK      = 8'h08;
  localparam logic [7:0] OFF_LASTWORD  = 8'h0c;
  localparam logic [7:0] OFF_FRAMES    = 8'h10;

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

  // Control register fields
  localparam int CTRL_ENABLE_BIT       = 0;

  // Global status register fields (sticky, read clears)
  localparam int GS_FRAME_DONE_BIT     = 0;
  localparam int GS_DESC_BACK_BIT      = 1;
  localparam int GS_WATCHDOG_BIT       = 9;
  localparam logic [31:0] GS_USED      = 32'h0000_0203;

  // Status word field positions
  localparam int SW_OWN_BIT            = 31;
  localparam int SW_ERR_SUM_BIT        = 15;
  localparam int SW_FIRST_BIT          = 9;
  localparam int SW_LAST_BIT           = 8;
  localparam int SW_OVERSIZE_BIT       = 7;
  localparam int SW_LATE_COLL_BIT      = 6;
  localparam int SW_TYPE_BIT           = 5;
  localparam int SW_WATCHDOG_BIT       = 4;
  localparam int SW_DRIBBLE_BIT        = 2;
  localparam int SW_CRC_BIT            = 1;
  localparam int SW_OVERFLOW_BIT       = 0;
  localparam logic [31:0] SW_LAST_ONLY = 32'h0000_00f7;

  // Frame limits in bytes and bits
  localparam logic [15:0] MAX_FRAME_BYTES   = 16'd1518;
  localparam logic [15:0] COLL_WINDOW_BYTES = 16'd64;
  localparam logic [15:0] TYPE_THRESHOLD    = 16'd1500;
  localparam logic [15:0] MIN_TYPE_BYTES    = 16'd14;
  localparam logic [15:0] WDOG_BYTES        = 16'd2048;
  localparam logic [15:0] LEN_HI_INDEX      = 16'd12;
  localparam logic [15:0] LEN_LO_INDEX      = 16'd13;
  localparam logic [2:0]  DRIBBLE_MIN_BITS  = 3'd2;

  // CRC-32, reflected form
  localparam logic [31:0] CRC_INIT     = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY     = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE  = 32'hdebb_20e3;

  typedef enum logic [1:0] {
    RSW_IDLE = 2'b00,
    RSW_RECV = 2'b01
  } rsw_state_t;

endpackage

// file: src/rsw_status.sv
// Receive status word builder with APB register slave
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module rsw_status (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive side of the MAC
  input  wire logic        rx_sof,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_eof,
  input  wire logic [2:0]  rx_extra_bits,
  input  wire logic        rx_collision,
  input  wire logic        rx_fifo_overflow,
  // Current descriptor buffer sizes
  input  wire logic [10:0] desc_buf1_size,
  input  wire logic [10:0] desc_buf2_size,
  // Status word write-back
  output logic             desc_wr,
  output logic [31:0]      rx_status_word,
  // Interrupt
  output logic             irq
);

  rsw_pkg::rsw_state_t state;
  rsw_pkg::rsw_state_t next_state;

  logic [31:0] ctrl;
  logic [31:0] mask;
  logic [31:0] gstat;
  logic [31:0] frames;
  logic [15:0] frame_bytes;
  logic [11:0] fill;
  logic [15:0] len_type;
  logic [31:0] crc;
  logic        first_pending;
  logic        late_coll;
  logic        overflow_seen;
  logic        wdog_seen;

  // Bytewise reflected CRC step
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ rsw_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // APB decode
  wire         apb_access = psel & penable;
  wire         apb_wr     = apb_access & pwrite;
  wire         apb_rd     = apb_access & ~pwrite;
  wire         sel_ctrl   = (paddr == rsw_pkg::OFF_CTRL);
  wire         sel_gstat  = (paddr == rsw_pkg::OFF_GSTAT);
  wire         sel_mask   = (paddr == rsw_pkg::OFF_MASK);
  wire         sel_last   = (paddr == rsw_pkg::OFF_LASTWORD);
  wire         sel_frames = (paddr == rsw_pkg::OFF_FRAMES);
  wire         mapped     = sel_ctrl | sel_gstat | sel_mask | sel_last | sel_frames;

  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;

  wire [31:0] rd_mux = sel_ctrl   ? ctrl :
                       sel_gstat  ? gstat :
                       sel_mask   ? mask :
                       sel_last   ? rx_status_word :
                       sel_frames ? frames : 32'h0000_0000;
  // Read data is taken in setup so it already stands at the zero-wait access edge
  wire        rd_setup    = psel & ~penable & ~pwrite;
  wire [31:0] next_prdata = rd_setup ? rd_mux : apb_rd ? prdata : 32'h0000_0000;

  // Frame datapath decode
  wire        enabled   = ctrl[rsw_pkg::CTRL_ENABLE_BIT];
  wire        in_frame  = (state == rsw_pkg::RSW_RECV);
  wire [11:0] capacity  = {1'b0, desc_buf1_size} + {1'b0, desc_buf2_size};
  // Sizes of the next descriptor show a cycle after write-back; wait for them
  wire        size_wait = desc_wr;
  // Both sizes zero: the frame cannot start here, so release it unused
  wire        skip_desc = in_frame & ~rx_eof & ~size_wait & (capacity == 12'h000);
  // Buffers full with more data pending: hand back a non-last descriptor
  wire        full_desc = in_frame & rx_byte_valid & ~rx_eof & (fill >= capacity)
                          & ~size_wait & ~skip_desc;
  // Bytes still count while a descriptor is skipped; they land in the next one
  wire        take_byte = in_frame & rx_byte_valid & ~rx_eof;
  wire        frame_end = in_frame & rx_eof;

  // Oversize is status only; bytes keep flowing past the limit
  wire        oversize  = frame_bytes > rsw_pkg::MAX_FRAME_BYTES;
  wire        runt      = frame_bytes < rsw_pkg::COLL_WINDOW_BYTES;
  wire        type_ok   = frame_bytes >= rsw_pkg::MIN_TYPE_BYTES;
  wire        type_enc  = type_ok & (len_type > rsw_pkg::TYPE_THRESHOLD);
  wire        dribble   = (rx_extra_bits > rsw_pkg::DRIBBLE_MIN_BITS)
                          & ~late_coll & ~runt;
  // Residue check over whole bytes only, extra bits never enter
  wire        crc_bad   = (crc != rsw_pkg::CRC_RESIDUE);
  wire        err_sum   = overflow_seen | crc_bad | late_coll | oversize | runt;

  wire [31:0] last_word = ({31'h0000_0000, overflow_seen} << rsw_pkg::SW_OVERFLOW_BIT)
                        | ({31'h0000_0000, crc_bad}       << rsw_pkg::SW_CRC_BIT)
                        | ({31'h0000_0000, dribble}       << rsw_pkg::SW_DRIBBLE_BIT)
                        | ({31'h0000_0000, wdog_seen}     << rsw_pkg::SW_WATCHDOG_BIT)
                        | ({31'h0000_0000, type_enc}      << rsw_pkg::SW_TYPE_BIT)
                        | ({31'h0000_0000, late_coll}     << rsw_pkg::SW_LATE_COLL_BIT)
                        | ({31'h0000_0000, oversize}      << rsw_pkg::SW_OVERSIZE_BIT)
                        | ({31'h0000_0000, err_sum}       << rsw_pkg::SW_ERR_SUM_BIT)
                        | (32'h0000_0001 << rsw_pkg::SW_LAST_BIT);
  // Ownership bit stays zero in every word written back
  wire [31:0] first_bit = {31'h0000_0000, first_pending} << rsw_pkg::SW_FIRST_BIT;
  wire [31:0] next_word = frame_end ? (last_word | first_bit) :
                          full_desc ? first_bit : 32'h0000_0000;
  wire        next_wr   = frame_end | full_desc | skip_desc;

  // Global status events; set wins over read clear
  wire [31:0] gs_set  = ({31'h0000_0000, frame_end} << rsw_pkg::GS_FRAME_DONE_BIT)
                      | ({31'h0000_0000, next_wr}   << rsw_pkg::GS_DESC_BACK_BIT)
                      | ({31'h0000_0000, frame_end & wdog_seen}
                         << rsw_pkg::GS_WATCHDOG_BIT);
  // Clear only what the read returned, so an event after the setup edge survives
  wire [31:0] gs_clr  = (apb_rd & sel_gstat) ? prdata : 32'h0000_0000;
  wire [31:0] next_gs = ((gstat & ~gs_clr) | gs_set) & rsw_pkg::GS_USED;

  always_comb begin
    case (state)
      rsw_pkg::RSW_IDLE: next_state = (rx_sof & enabled) ? rsw_pkg::RSW_RECV
                                                         : rsw_pkg::RSW_IDLE;
      rsw_pkg::RSW_RECV: next_state = rx_eof ? rsw_pkg::RSW_IDLE : rsw_pkg::RSW_RECV;
      default:           next_state = rsw_pkg::RSW_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= rsw_pkg::CTRL_RESET;
      mask   <= rsw_pkg::MASK_RESET;
      gstat  <= 32'h0000_0000;
      prdata <= 32'h0000_0000;
    end else begin
      if (apb_wr & sel_ctrl) begin
        ctrl <= pwdata & 32'h0000_0001;
      end
      if (apb_wr & sel_mask) begin
        mask <= pwdata & rsw_pkg::GS_USED;
      end
      gstat  <= next_gs;
      prdata <= next_prdata;
    end
  end

  assign irq = |(gstat & mask);

  // Frame tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= rsw_pkg::RSW_IDLE;
      frame_bytes   <= 16'h0000;
      fill          <= 12'h000;
      len_type      <= 16'h0000;
      crc           <= rsw_pkg::CRC_INIT;
      first_pending <= 1'b0;
      late_coll     <= 1'b0;
      overflow_seen <= 1'b0;
      wdog_seen     <= 1'b0;
      frames        <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (state == rsw_pkg::RSW_IDLE) begin
        frame_bytes   <= 16'h0000;
        fill          <= 12'h000;
        len_type      <= 16'h0000;
        crc           <= rsw_pkg::CRC_INIT;
        first_pending <= 1'b1;
        late_coll     <= 1'b0;
        overflow_seen <= 1'b0;
        wdog_seen     <= 1'b0;
      end else begin
        if (full_desc) begin
          first_pending <= 1'b0;
          fill          <= 12'h001;
        end else if (take_byte) begin
          fill <= fill + 12'h001;
        end
        if (take_byte) begin
          frame_bytes <= frame_bytes + 16'h0001;
          crc         <= crc_step(crc, rx_byte);
          if (frame_bytes == rsw_pkg::LEN_HI_INDEX) begin
            len_type[15:8] <= rx_byte;
          end
          if (frame_bytes == rsw_pkg::LEN_LO_INDEX) begin
            len_type[7:0] <= rx_byte;
          end
          // Watchdog measured in bytes so it tracks packet length, not wall time
          if (frame_bytes + 16'h0001 == rsw_pkg::WDOG_BYTES) begin
            wdog_seen <= 1'b1;
          end
        end
        if (rx_collision & (frame_bytes >= rsw_pkg::COLL_WINDOW_BYTES)) begin
          late_coll <= 1'b1;
        end
        if (rx_fifo_overflow) begin
          overflow_seen <= 1'b1;
        end
      end
      if (frame_end) begin
        frames <= frames + 32'h0000_0001;
      end
    end
  end

  // Write-back word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_wr        <= 1'b0;
      rx_status_word <= 32'h0000_0000;
    end else begin
      desc_wr <= next_wr;
      if (next_wr) begin
        rx_status_word <= next_word;
      end
    end
  end

  // Checks
  AST_OWN_RETURNED: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr |-> !rx_status_word[rsw_pkg::SW_OWN_BIT])
    else $error("Ownership not returned to host");

  AST_ERR_SUMMARY: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr && (rx_status_word[0] || rx_status_word[1] || rx_status_word[6]
                || rx_status_word[7]) |-> rx_status_word[15])
    else $error("Error summary missing");

  AST_LAST_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr && !rx_status_word[8] |-> (rx_status_word & rsw_pkg::SW_LAST_ONLY) == 0)
    else $error("Error flag in non-last descriptor");

  AST_WDOG_GLOBAL: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr && rx_status_word[4] |-> gstat[9])
    else $error("Watchdog flag without global status");

  AST_DRIBBLE_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr && rx_status_word[6] |-> !rx_status_word[2])
    else $error("Dribble flag with late collision");

  AST_OVERSIZE: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes > 16'd1518 |=> desc_wr && rx_status_word[7])
    else $error("Oversize frame not flagged");

  AST_TYPE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes < 16'd14 |=> desc_wr && !rx_status_word[5])
    else $error("Type flag on short runt");

  AST_CRC_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |=> desc_wr && rx_status_word[1] == ($past(crc) != 32'hdebb_20e3))
    else $error("CRC flag mismatch");

  AST_FIRST_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    desc_wr && rx_status_word[9] ##1 desc_wr && !$past(frame_end, 2)
    |-> !rx_status_word[9])
    else $error("First flag repeated within frame");

  AST_FIRST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    in_frame && first_pending && (frame_end || full_desc) |=> rx_status_word[9])
    else $error("First flag missing");

  AST_SKIP_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    skip_desc |=> desc_wr && rx_status_word == 32'h0000_0000)
    else $error("Skipped descriptor word not empty");

  AST_SKIP_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    take_byte && skip_desc |=> frame_bytes == $past(frame_bytes) + 16'h0001)
    else $error("Byte lost while skipping descriptor");

  AST_LAST_AT_END: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |=> desc_wr && rx_status_word[8])
    else $error("Last flag missing at frame end");

  AST_FULL_RETURNS: assert property (@(posedge pclk) disable iff (!presetn)
    full_desc |=> desc_wr && !rx_status_word[8] && !rx_status_word[31])
    else $error("Full descriptor not handed back");

  AST_MAX_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes <= 16'd1518 |=> !rx_status_word[7])
    else $error("Oversize flag on legal length");

  AST_NO_TRUNCATE: assert property (@(posedge pclk) disable iff (!presetn)
    take_byte && oversize |=> frame_bytes == $past(frame_bytes) + 16'h0001)
    else $error("Oversize frame truncated");

  AST_LATE_COLL: assert property (@(posedge pclk) disable iff (!presetn)
    in_frame && rx_collision && frame_bytes >= 16'd64 |=> late_coll)
    else $error("Late collision not recorded");

  AST_EARLY_COLL: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && !late_coll |=> !rx_status_word[6])
    else $error("Collision flag without late collision");

  AST_TYPE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes >= 16'd14 && len_type > 16'd1500 |=> rx_status_word[5])
    else $error("Type flag missing");

  AST_TYPE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && len_type <= 16'd1500 |=> !rx_status_word[5])
    else $error("Type flag on length frame");

  AST_WDOG_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes >= 16'd2048 |=> rx_status_word[4])
    else $error("Watchdog flag missing");

  AST_WDOG_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes < 16'd2048 |=> !rx_status_word[4])
    else $error("Watchdog flag on short frame");

  AST_DRIBBLE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && rx_extra_bits > 3'd2 && !late_coll && frame_bytes >= 16'd64
    |=> rx_status_word[2])
    else $error("Dribble flag missing");

  AST_DRIBBLE_FEW: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && rx_extra_bits <= 3'd2 |=> !rx_status_word[2])
    else $error("Dribble flag with two or fewer bits");

  AST_DRIBBLE_RUNT: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && frame_bytes < 16'd64 |=> !rx_status_word[2])
    else $error("Dribble flag on runt");

  AST_OVERFLOW_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
    in_frame && rx_fifo_overflow |=> overflow_seen)
    else $error("Overflow not recorded");

  AST_OVERFLOW_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end && overflow_seen |=> rx_status_word[0])
    else $error("Overflow flag missing");

  AST_DONE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    frame_end |=> gstat[0] && gstat[1])
    else $error("Frame done status not set");

  AST_GS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rd && sel_gstat && !next_wr |=> (gstat & $past(prdata)) == 32'h0000_0000)
    else $error("Status read did not clear");

  AST_RD_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rd && sel_ctrl |-> prdata == ctrl)
    else $error("Control read data not valid at access");

  AST_RD_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rd && sel_mask |-> prdata == mask)
    else $error("Mask read data not valid at access");

  AST_BAD_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr && !mapped |=> $stable(ctrl) && $stable(mask))
    else $error("Unmapped write changed a register");

endmodule // rsw_status
